// ### hw/pmt8_consts.vh
// constants for the 8-bit period match timer: register map, fields, resets
// assumes a classic wishbone slave with 32-bit data on one clock, mclk
// Functional notes
// - counts instruction clock through the prescaler
// - prescale select: 00 div1, 01 div4, 1x div16
// - prescaled ticks increment count, compared to period
// - match reloads zero and advances postscaler
// - postscale select n divides matches by n+1
// - postscaler output sets sticky match flag
// - count resets 00h, period resets FFh
// - timer runs only while run_enable set
// - count or control writes clear scalers
// - control write leaves count unchanged
`ifndef PMT8_CONSTS_VH
`define PMT8_CONSTS_VH
`define PMT8_ADR_COUNT 4'h0
`define PMT8_ADR_PERIOD 4'h1
`define PMT8_ADR_CONTROL 4'h2
`define PMT8_ADR_FLAGS 4'h3
`define PMT8_ADR_MASK 4'h4
`define PMT8_COUNT_RST 8'h00
`define PMT8_PERIOD_RST 8'hFF
`define PMT8_CONTROL_RST 7'h00
`define PMT8_CTRL_MASK 8'h7F
`define PMT8_RUN_BIT 2
`define PMT8_POST_LSB 3
`define PMT8_POST_MSB 6
`define PMT8_PRE_LSB 0
`define PMT8_PRE_MSB 1
`define PMT8_PRE_DIV1 2'h0
`define PMT8_PRE_DIV4 2'h1
`define PMT8_PRE_TERM4 4'h3
`define PMT8_PRE_TERM16 4'hF
`define PMT8_PRE_ZERO 4'h0
`define PMT8_PRE_ONE 4'h1
`define PMT8_POST_ZERO 4'h0
`define PMT8_POST_ONE 4'h1
`define PMT8_CNT_ONE 8'h01
`define PMT8_ZERO32 32'h00000000
`endif

// ### hw/pmt8_timer.v
// 8-bit period match timer with pre/postscaler and wishbone registers
// assumes mclk is the instruction clock and a classic wishbone master
//
// Our own choices: the register offsets and the Wishbone slave port.
`include "pmt8_consts.vh"
module pmt8_timer
(
  // clock and reset
  input wire mclk,
  input wire sys_rst,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg wb_err_o,
  // interrupt
  output reg irq
);
  reg [7:0] count_value;
  reg [7:0] period_value;
  reg [6:0] timer_control;
  reg [3:0] pre_cnt;
  reg [3:0] post_cnt;
  reg match_irq_flag;
  reg irq_mask;
  reg [31:0] next_dat;
  reg next_err;
  wire [3:0] word_adr = wb_adr_i[5:2];
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire wr = req & wb_we_i & wb_sel_i[0];
  wire run_enable = timer_control[`PMT8_RUN_BIT];
  wire [1:0] prescale_select = timer_control[`PMT8_PRE_MSB:`PMT8_PRE_LSB];
  wire [3:0] postscale_select = timer_control[`PMT8_POST_MSB:`PMT8_POST_LSB];
  wire wr_count = wr & (word_adr == `PMT8_ADR_COUNT);
  wire wr_period = wr & (word_adr == `PMT8_ADR_PERIOD);
  wire wr_control = wr & (word_adr == `PMT8_ADR_CONTROL);
  wire wr_flags = wr & (word_adr == `PMT8_ADR_FLAGS);
  wire wr_mask = wr & (word_adr == `PMT8_ADR_MASK);
  reg [3:0] pre_term;
  wire tick;
  wire match;
  wire post_out;

  reg [3:0] next_pre;
  reg [3:0] next_post;
  reg [7:0] next_count;
  reg [7:0] next_period;
  reg [6:0] next_control;
  reg next_flag;
  reg next_mask;
  wire clear_scalers;
  wire flag_clear;

  // prescaler terminal count from select
  always @*
  begin
    if (prescale_select == `PMT8_PRE_DIV1)
    begin
      pre_term = `PMT8_PRE_ZERO;
    end
    else if (prescale_select == `PMT8_PRE_DIV4)
    begin
      pre_term = `PMT8_PRE_TERM4;
    end
    else
    begin
      pre_term = `PMT8_PRE_TERM16;
    end
  end

  // mclk stands for the instruction clock; tick once per divided period
  assign tick = run_enable & (pre_cnt == pre_term);
  assign match = count_value == period_value;
  assign post_out = tick & match & (post_cnt == postscale_select);
  // restart both scalers so a new setting takes a full period
  assign clear_scalers = wr_count | wr_control;
  assign flag_clear = wr_flags & wb_dat_i[0];

  // prescaler next value
  always @*
  begin
    if (clear_scalers)
    begin
      next_pre = `PMT8_PRE_ZERO;
    end
    else if (!run_enable)
    begin
      next_pre = pre_cnt;
    end
    else if (tick)
    begin
      next_pre = `PMT8_PRE_ZERO;
    end
    else
    begin
      next_pre = pre_cnt + `PMT8_PRE_ONE;
    end
  end

  // postscaler next value, advances on each match tick
  always @*
  begin
    if (clear_scalers)
    begin
      next_post = `PMT8_POST_ZERO;
    end
    else if (post_out)
    begin
      next_post = `PMT8_POST_ZERO;
    end
    else if (tick & match)
    begin
      next_post = post_cnt + `PMT8_POST_ONE;
    end
    else
    begin
      next_post = post_cnt;
    end
  end

  // count next value; software write wins over a tick
  always @*
  begin
    if (wr_count)
    begin
      next_count = wb_dat_i[7:0];
    end
    else if (tick & match)
    begin
      next_count = `PMT8_COUNT_RST;
    end
    else if (tick)
    begin
      next_count = count_value + `PMT8_CNT_ONE;
    end
    else
    begin
      next_count = count_value;
    end
  end

  // period next value
  always @*
  begin
    if (wr_period)
    begin
      next_period = wb_dat_i[7:0];
    end
    else
    begin
      next_period = period_value;
    end
  end

  // control next value, bit 7 not stored so it reads zero
  always @*
  begin
    if (wr_control)
    begin
      next_control = wb_dat_i[6:0];
    end
    else
    begin
      next_control = timer_control;
    end
  end

  // sticky flag: a new event wins over a write-one clear
  always @*
  begin
    if (post_out)
    begin
      next_flag = 1'b1;
    end
    else if (flag_clear)
    begin
      next_flag = 1'b0;
    end
    else
    begin
      next_flag = match_irq_flag;
    end
  end

  // interrupt mask next value
  always @*
  begin
    if (wr_mask)
    begin
      next_mask = wb_dat_i[0];
    end
    else
    begin
      next_mask = irq_mask;
    end
  end

  // timer state
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      pre_cnt <= `PMT8_PRE_ZERO;
      post_cnt <= `PMT8_POST_ZERO;
      count_value <= `PMT8_COUNT_RST;
      period_value <= `PMT8_PERIOD_RST;
    end
    else
    begin
      pre_cnt <= next_pre;
      post_cnt <= next_post;
      count_value <= next_count;
      period_value <= next_period;
    end
  end

  // control and interrupt state
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      timer_control <= `PMT8_CONTROL_RST;
      match_irq_flag <= 1'b0;
      irq_mask <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      timer_control <= next_control;
      match_irq_flag <= next_flag;
      irq_mask <= next_mask;
      // one cycle behind the flag, keeps irq a plain flop
      irq <= match_irq_flag & irq_mask;
    end
  end

  // read mux and unmapped decode
  always @*
  begin
    next_dat = `PMT8_ZERO32;
    next_err = 1'b0;
    if (word_adr == `PMT8_ADR_COUNT)
    begin
      next_dat[7:0] = count_value;
    end
    else if (word_adr == `PMT8_ADR_PERIOD)
    begin
      next_dat[7:0] = period_value;
    end
    else if (word_adr == `PMT8_ADR_CONTROL)
    begin
      next_dat[6:0] = timer_control;
    end
    else if (word_adr == `PMT8_ADR_FLAGS)
    begin
      next_dat[0] = match_irq_flag;
    end
    else if (word_adr == `PMT8_ADR_MASK)
    begin
      next_dat[0] = irq_mask;
    end
    else
    begin
      // unmapped: answer with err so software sees the slip
      next_err = 1'b1;
    end
  end

  // one wait state; ack or err drops the cycle after
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= `PMT8_ZERO32;
    end
    else
    begin
      wb_ack_o <= req & ~next_err;
      wb_err_o <= req & next_err;
      wb_dat_o <= req ? next_dat : `PMT8_ZERO32;
    end
  end
endmodule

// ### tb/pmt8_timer_asserts.sv
// port checks for the timer
// assumes bind onto pmt8_timer, one clock
module pmt8_chk (
  // clock, reset
  input wire mclk,
  input wire sys_rst,
  // bus, irq
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire wb_err_o,
  input wire irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire take = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire bad = wb_adr_i[5:2] > 4'h4;
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  ack_time_a: assert property (take |=> wb_ack_o != $past(bad)) else $error("no ack");
  err_map_a: assert property (take |=> wb_err_o == $past(bad)) else $error("bad err");
  ack_cause_a: assert property (wb_ack_o |-> $past(take)) else $error("stray ack");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat idle");
  dat_byte_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("dat high");
  ctl_top_a: assert property (wb_ack_o && $past(wb_adr_i) == 6'h08 |-> !wb_dat_o[7]) else $error("bit7");
  mask_off_a: assert property (take && wb_we_i && wb_adr_i == 6'h10 && wb_sel_i[0] && !wb_dat_i[0] |=> ##1 !irq)
    else $error("irq masked");
  cover property ($rose(irq));
  cover property (wb_err_o);
  cover property (wb_ack_o && wb_dat_o[7:0] == 8'hFF);
endmodule
bind pmt8_timer pmt8_chk i_chk (.*);

// ### tb/test_pmt8_timer.sv
// self-checking bench for the timer
// assumes the map 0x00..0x10 of the timer
module test_pmt8_timer;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0;
  logic sys_rst = 1;
  logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [5:0] wb_adr_i = 6'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, wb_err_o, irq;
  int fail_count = 0, total_checks = 0, t0;
  bit [31:0] seed = 32'h2;
  logic [8:0] exp_q[$];
  always #2 mclk = ~mclk;
  pmt8_timer i_dut (.*);
  function automatic bit [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input string nm, input logic [8:0] s, e);
    total_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic tally_and_finish();
    if (fail_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // err in bit 8, so a refused read queues like any other
  task automatic wb(input logic we, input logic [5:0] a, input logic [7:0] d, input logic [8:0] e);
    int n;
    if (!we)
      exp_q.push_back(e);
    @(posedge mclk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, we, a, 4'hF, 24'h0, d};
    for (n = 0; n < 9 && !(wb_ack_o | wb_err_o); n++)
      @(posedge mclk);
    if (n == 9)
    begin
      fail_count++;
      tally_and_finish();
    end
    t0 = $time;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
  always @(posedge mclk)
    if ((wb_ack_o | wb_err_o) && !wb_we_i)
      check("rd_data", {wb_err_o, wb_dat_o[7:0]}, exp_q.pop_front());
  initial
  begin
    int p, w, k;
    repeat (16) @(posedge mclk);
    sys_rst <= 0;
    wb(0, 6'h00, 8'h0, 9'h000);
    wb(0, 6'h04, 8'h0, 9'h0FF);
    wb(1, 6'h08, 8'h80, 9'h0);
    wb(0, 6'h08, 8'h0, 9'h000);
    wb(0, 6'h14, 8'h0, 9'h100);
    for (int i = 0; i < 8; i++)
    begin
      p = rnd() % 16;
      wb(1, 6'h04, p[7:0], 9'h0);
      wb(1, 6'h00, 8'h0, 9'h0);
      wb(1, 6'h08, {5'h1, i[1:0]}, 9'h0);
      k = t0;
      repeat (rnd() % 64) @(posedge mclk);
      wb(1, 6'h08, {6'h0, i[1:0]}, 9'h0);
      // ticks per stretch: 4 ns cycles over the prescale ratio
      k = (t0 - k) / (i % 4 == 0 ? 4 : i % 4 == 1 ? 16 : 64) % (p + 1);
      repeat (5) @(posedge mclk);
      wb(0, 6'h00, 8'h0, k[8:0]);
    end
    wb(1, 6'h04, 8'h02, 9'h0);
    wb(1, 6'h00, 8'h0, 9'h0);
    // matches in the loop above may have left the flag set
    wb(1, 6'h0C, 8'h01, 9'h0);
    wb(1, 6'h10, 8'h01, 9'h0);
    wb(1, 6'h08, 8'h7C, 9'h0);
    for (w = 0; w < 99 && !irq; w++)
      @(posedge mclk);
    check("irq_time", w > 46 && w < 51, 1'b1);
    if (w == 99)
      tally_and_finish();
    wb(1, 6'h08, 8'h78, 9'h0);
    wb(0, 6'h0C, 8'h0, 9'h001);
    wb(1, 6'h0C, 8'h01, 9'h0);
    wb(0, 6'h0C, 8'h0, 9'h000);
    check("irq_clear", irq, 1'b0);
    wb(1, 6'h10, 8'h0, 9'h0);
    tally_and_finish();
  end
endmodule
